// ===== rtl/pfc_map.svh
// constants for the paper feeder controller: timing counts and encodings
// assumes inclusion by the lifter and feeder design files
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
`define PFC_LIFT_TIMEOUT_CYC   32'd200000
`define PFC_LEAD_TIMEOUT_CYC   32'd20000
`define PFC_TRAIL_TIMEOUT_CYC  32'd40000
`define PFC_RESID_TIME_CYC     32'd20000
`define PFC_DELIVER_TIME_CYC   32'd100000
`define PFC_PICK_RETRIES       2'h2
`define PFC_SW_UNIVERSAL       3'h7
`define PFC_SW_A5              3'h1
`define PFC_SW_B5              3'h3
`define PFC_SW_EXEC            3'h5
`define PFC_SW_LETTER          3'h2
`define PFC_SW_A4              3'h4
`define PFC_SW_LEGAL           3'h6
`define PFC_SW_NONE            3'h0
`endif

// ===== rtl/pfc_pkg.sv
// types for the paper feeder controller
// assumes pfc_map.svh on the include path
package pfc_pkg;
	typedef enum logic [3:0] {
		SZ_NONE      = 4'h0,
		SZ_UNIVERSAL = 4'h1,
		SZ_A5        = 4'h2,
		SZ_B5        = 4'h3,
		SZ_EXEC      = 4'h4,
		SZ_LETTER    = 4'h5,
		SZ_A4        = 4'h6,
		SZ_LEGAL     = 4'h7
	} pfc_size_t;

	typedef enum logic [2:0] {
		FD_IDLE  = 3'h0,
		FD_LEAD  = 3'h1,
		FD_TRAIL = 3'h2,
		FD_DELIV = 3'h3,
		FD_JAM   = 3'h4
	} pfc_feed_st_t;

	typedef struct packed {
		logic pick_delay;
		logic pick_delay2;
		logic stat1;
		logic stat2;
		logic residual;
		logic door_open;
	} pfc_jam_t;
endpackage

// ===== rtl/pfc_lifter.sv
// one cassette lifter: lift on power-up, insertion or surface drop
// assumes synchronous sensor inputs, high when the surface is detected
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_lifter #(
	parameter int unsigned LIFT_TIMEOUT = `PFC_LIFT_TIMEOUT_CYC
) (
	input  wire logic i_core_clk,
	input  wire logic i_sys_rst,
	// tray status
	input  wire logic i_present,
	input  wire logic i_surf_a,
	input  wire logic i_surf_b,
	// drive and failure
	output logic      o_motor,
	output logic      o_fail
);
	initial begin
		if (LIFT_TIMEOUT < 1) $error("lift timeout must be at least one");
	end

	logic [31:0] cnt_reg;
	logic        surf;
	logic        start;

	assign surf  = i_surf_a & i_surf_b;
	// power-up, insertion and a lowered stack all show as no surface
	assign start = i_present & ~o_motor & ~o_fail & ~surf;

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_motor <= 1'b0;
			cnt_reg <= 32'h0000_0000;
		end else if (!i_present || surf || o_fail) begin
			o_motor <= 1'b0;
			cnt_reg <= 32'h0000_0000;
		end else if (start) begin
			o_motor <= 1'b1;
			cnt_reg <= 32'h0000_0000;
		end else if (o_motor) begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_fail <= 1'b0;
		else if (!i_present)
			o_fail <= 1'b0;
		else if (o_motor && !surf && cnt_reg >= LIFT_TIMEOUT - 1)
			o_fail <= 1'b1;
	end
endmodule

// ===== rtl/pfc_feeder.sv
// What this block does
// - switches all on: universal; off,off,on: A5; off,on,on: B5; on,off,on: executive
// - off,on,off letter; on,off,off A4; on,on,off legal; all off no cassette
// - lift starts at power-up, cassette insertion, and stack surface drop
// - lifter motor runs up until both of that tray's surface sensors trip
// - while printing, lowered surface restarts the lifter motor
// - no surface within timeout after motor start flags lifter failure
// - either surface sensor missing the surface in time reports failure
// - one-tray: one lifter plus pickup motor; three-tray: three lifters plus pickup
// - each pickup feeds exactly one sheet from the selected cassette
// - one-tray: no leading edge after two retries gives pickup delay jam
// - one-tray: no trailing edge in time gives stationary jam
// - one-tray: paper held during automatic delivery gives residual jam
// - three-tray: any feed sensor missing leading edge gives delay jam
// - three-tray: upper sensor missing leading edge gives delay jam 2
// - three-tray: middle or lower missing trailing edge gives stationary jam 1
// - three-tray: upper missing trailing edge gives stationary jam 2
// - three-tray: any feed sensor held during delivery gives residual jam
// - door open during feed gives door-open jam
// - leftover paper at initialization triggers automatic delivery
// feeder top: lifters, size decode, pickup sequencing, jam detection
// assumes sensors are synchronous to i_core_clk, high meaning active
`timescale 1ns/1ps
`include "pfc_map.svh"
module pfc_feeder #(
	parameter int unsigned TRAYS         = 3,
	parameter int unsigned LIFT_TIMEOUT  = `PFC_LIFT_TIMEOUT_CYC,
	parameter int unsigned LEAD_TIMEOUT  = `PFC_LEAD_TIMEOUT_CYC,
	parameter int unsigned TRAIL_TIMEOUT = `PFC_TRAIL_TIMEOUT_CYC,
	parameter int unsigned RESID_TIME    = `PFC_RESID_TIME_CYC,
	parameter int unsigned DELIVER_TIME  = `PFC_DELIVER_TIME_CYC
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_sys_rst,
	// engine requests
	input  wire logic              i_pick_req,
	input  wire logic [1:0]        i_pick_tray,
	input  wire logic              i_printing,
	input  wire logic              i_jam_clear,
	// switches and sensors, tray 0 is the upper tray
	input  wire logic [2:0]        i_upper_size_switches,
	input  wire logic [2:0]        i_middle_size_switches,
	input  wire logic [2:0]        i_lower_size_switches,
	input  wire logic [2:0]        i_surface_a,
	input  wire logic [2:0]        i_surface_b,
	input  wire logic              i_upper_feed_sensor,
	input  wire logic              i_middle_feed_sensor,
	input  wire logic              i_lower_feed_sensor,
	input  wire logic              i_right_door_switch,
	// motors and solenoids
	output logic                   o_upper_lifter_motor,
	output logic                   o_middle_lifter_motor,
	output logic                   o_lower_lifter_motor,
	output logic                   o_pickup_motor,
	output logic [2:0]             o_pickup_solenoid,
	// status to the engine
	output pfc_pkg::pfc_size_t [2:0] o_size,
	output logic [2:0]             o_lifter_fail,
	output pfc_pkg::pfc_jam_t      o_jam,
	output logic                   o_busy,
	output logic                   o_sheet_done
);
	initial begin
		if (TRAYS != 1 && TRAYS != 3) $error("trays must be 1 or 3");
		if (LEAD_TIMEOUT < 1 || TRAIL_TIMEOUT < 1 || RESID_TIME < 1 ||
		    DELIVER_TIME < 1) $error("counts must be at least one");
	end

	function automatic pfc_pkg::pfc_size_t decode_size(input logic [2:0] sw);
		case (sw) // top, center, bottom
		`PFC_SW_UNIVERSAL: decode_size = pfc_pkg::SZ_UNIVERSAL;
		`PFC_SW_A5:        decode_size = pfc_pkg::SZ_A5;
		`PFC_SW_B5:        decode_size = pfc_pkg::SZ_B5;
		`PFC_SW_EXEC:      decode_size = pfc_pkg::SZ_EXEC;
		`PFC_SW_LETTER:    decode_size = pfc_pkg::SZ_LETTER;
		`PFC_SW_A4:        decode_size = pfc_pkg::SZ_A4;
		`PFC_SW_LEGAL:     decode_size = pfc_pkg::SZ_LEGAL;
		default:           decode_size = pfc_pkg::SZ_NONE;
		endcase
	endfunction

	localparam int unsigned NT = TRAYS;

	logic [2:0] sw [3];
	logic [2:0] present;
	logic [2:0] motor;
	logic [2:0] fail;
	logic [2:0] feed;

	assign sw[0] = i_upper_size_switches;
	assign sw[1] = i_middle_size_switches;
	assign sw[2] = i_lower_size_switches;
	assign feed  = {i_lower_feed_sensor, i_middle_feed_sensor,
		i_upper_feed_sensor};

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			o_size <= '{default: pfc_pkg::SZ_NONE};
		else
			for (int t = 0; t < 3; t++)
				o_size[t] <= (t < NT) ? decode_size(sw[t]) : pfc_pkg::SZ_NONE;
	end

	// lifters are built for all three trays, enabled only for fitted trays
	for (genvar t = 0; t < 3; t++) begin : g_lift
		assign present[t] = (t < NT) && (sw[t] != `PFC_SW_NONE);
		pfc_lifter #(.LIFT_TIMEOUT(LIFT_TIMEOUT)) u_lift (
			.i_core_clk(i_core_clk),
			.i_sys_rst (i_sys_rst),
			.i_present (present[t]),
			.i_surf_a  (i_surface_a[t]),
			.i_surf_b  (i_surface_b[t]),
			.o_motor   (motor[t]),
			.o_fail    (fail[t])
		);
	end

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_upper_lifter_motor  <= 1'b0;
			o_middle_lifter_motor <= 1'b0;
			o_lower_lifter_motor  <= 1'b0;
			o_lifter_fail         <= 3'h0;
		end else begin
			o_upper_lifter_motor  <= motor[0];
			o_middle_lifter_motor <= motor[1];
			o_lower_lifter_motor  <= motor[2];
			o_lifter_fail         <= fail;
		end
	end

	// pickup and jam sequencing
	pfc_pkg::pfc_feed_st_t st_reg;
	logic [31:0] tmr_reg;
	logic [31:0] res_reg;
	logic [1:0]  tray_reg;
	logic [1:0]  try_reg;
	logic        init_reg;
	logic        sel_feed;
	logic        any_paper;

	assign sel_feed  = feed[tray_reg];
	assign any_paper = |(feed & present_mask(NT));

	function automatic logic [2:0] present_mask(input int unsigned n);
		present_mask = (n == 1) ? 3'h1 : 3'h7;
	endfunction

	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_reg            <= pfc_pkg::FD_IDLE;
			tmr_reg           <= 32'h0000_0000;
			res_reg           <= 32'h0000_0000;
			tray_reg          <= 2'h0;
			try_reg           <= 2'h0;
			init_reg          <= 1'b1;
			o_jam             <= '0;
			o_pickup_motor    <= 1'b0;
			o_pickup_solenoid <= 3'h0;
			o_busy            <= 1'b0;
			o_sheet_done      <= 1'b0;
		end else begin
			o_sheet_done <= 1'b0;
			if (o_busy && i_right_door_switch && st_reg != pfc_pkg::FD_JAM) begin
				o_jam.door_open   <= 1'b1;
				st_reg            <= pfc_pkg::FD_JAM;
				o_pickup_motor    <= 1'b0;
				o_pickup_solenoid <= 3'h0;
			end else begin
				case (st_reg)
				pfc_pkg::FD_IDLE: begin
					o_busy <= 1'b0;
					if (init_reg) begin
						init_reg <= 1'b0;
						if (any_paper) begin
							st_reg         <= pfc_pkg::FD_DELIV;
							o_pickup_motor <= 1'b1;
							o_busy         <= 1'b1;
							tmr_reg        <= 32'h0000_0000;
							res_reg        <= 32'h0000_0000;
						end
					end else if (i_pick_req && i_pick_tray < 2'(NT) &&
					             present[i_pick_tray] && !fail[i_pick_tray]) begin
						tray_reg          <= i_pick_tray;
						try_reg           <= 2'h0;
						tmr_reg           <= 32'h0000_0000;
						o_pickup_motor    <= 1'b1;
						o_pickup_solenoid <= 3'h1 << i_pick_tray;
						o_busy            <= 1'b1;
						st_reg            <= pfc_pkg::FD_LEAD;
					end
				end
				pfc_pkg::FD_LEAD: begin
					o_pickup_solenoid <= 3'h0;
					if (sel_feed) begin
						tmr_reg <= 32'h0000_0000;
						st_reg  <= pfc_pkg::FD_TRAIL;
					end else if (tmr_reg >= LEAD_TIMEOUT - 1) begin
						tmr_reg <= 32'h0000_0000;
						if (try_reg == `PFC_PICK_RETRIES) begin
							o_jam.pick_delay <= 1'b1;
							if (NT == 3 && tray_reg == 2'h0)
								o_jam.pick_delay2 <= 1'b1;
							o_pickup_motor <= 1'b0;
							st_reg         <= pfc_pkg::FD_JAM;
						end else begin
							try_reg           <= try_reg + 2'h1;
							o_pickup_solenoid <= 3'h1 << tray_reg;
						end
					end else
						tmr_reg <= tmr_reg + 32'h0000_0001;
				end
				pfc_pkg::FD_TRAIL: begin
					if (!sel_feed) begin
						o_pickup_motor <= 1'b0;
						o_sheet_done   <= 1'b1;
						st_reg         <= pfc_pkg::FD_IDLE;
					end else if (tmr_reg >= TRAIL_TIMEOUT - 1) begin
						if (NT == 3 && tray_reg != 2'h0)
							o_jam.stat1 <= 1'b1;
						else if (NT == 3)
							o_jam.stat2 <= 1'b1;
						else
							o_jam.stat1 <= 1'b1;
						o_pickup_motor <= 1'b0;
						st_reg         <= pfc_pkg::FD_JAM;
					end else
						tmr_reg <= tmr_reg + 32'h0000_0001;
				end
				pfc_pkg::FD_DELIV: begin
					res_reg <= any_paper ? res_reg + 32'h0000_0001 : 32'h0000_0000;
					tmr_reg <= tmr_reg + 32'h0000_0001;
					if (any_paper && res_reg >= RESID_TIME - 1) begin
						o_jam.residual <= 1'b1;
						o_pickup_motor <= 1'b0;
						st_reg         <= pfc_pkg::FD_JAM;
					end else if (!any_paper && tmr_reg >= DELIVER_TIME - 1) begin
						o_pickup_motor <= 1'b0;
						st_reg         <= pfc_pkg::FD_IDLE;
					end
				end
				pfc_pkg::FD_JAM: begin
					o_busy <= 1'b0;
					if (i_jam_clear && !i_right_door_switch) begin
						o_jam    <= '0;
						init_reg <= 1'b1; // recheck leftover paper
						st_reg   <= pfc_pkg::FD_IDLE;
					end
				end
				default: st_reg <= pfc_pkg::FD_IDLE;
				endcase
			end
		end
	end
endmodule

// ===== verif/pfc_feeder_sva.sv
// port assertions for the feeder top
// assumes bind into pfc_feeder, one clock domain
`timescale 1ns/1ps
module pfc_feeder_sva (
	// clock and reset
	input wire logic                     i_core_clk,
	input wire logic                     i_sys_rst,
	// inputs
	input wire logic [2:0]               i_upper_size_switches,
	input wire logic [2:0]               i_middle_size_switches,
	input wire logic [2:0]               i_surface_a,
	input wire logic [2:0]               i_surface_b,
	input wire logic                     i_right_door_switch,
	input wire logic                     i_jam_clear,
	// outputs
	input wire logic                     o_middle_lifter_motor,
	input wire logic                     o_lower_lifter_motor,
	input wire logic [2:0]               o_pickup_solenoid,
	input wire pfc_pkg::pfc_size_t [2:0] o_size,
	input wire logic [2:0]               o_lifter_fail,
	input wire pfc_pkg::pfc_jam_t        o_jam,
	input wire logic                     o_busy,
	input wire logic                     o_sheet_done
);
	default clocking dc @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);
	property p_size;
		!$past(i_sys_rst) && $past(i_upper_size_switches) == 3'h7
			|-> o_size[0] == pfc_pkg::SZ_UNIVERSAL;
	endproperty
	a_size: assert property (p_size) else $error("size decode");
	property p_stop;
		(i_surface_a[1] && i_surface_b[1])[*3] |-> !o_middle_lifter_motor;
	endproperty
	a_stop: assert property (p_stop) else $error("lifter not stopped");
	property p_relift;
		(i_middle_size_switches != 3'h0 && !i_surface_a[1]
			&& !o_lifter_fail[1])[*3] ##1 !o_lifter_fail[1]
			|-> o_middle_lifter_motor;
	endproperty
	a_relift: assert property (p_relift) else $error("no lift");
	property p_fail;
		$rose(o_lifter_fail[2]) |-> $past(o_lower_lifter_motor);
	endproperty
	a_fail: assert property (p_fail) else $error("fail w/o motor");
	property p_sol;
		|o_pickup_solenoid |=> o_pickup_solenoid == 3'h0;
	endproperty
	a_sol: assert property (p_sol) else $error("solenoid held");
	property p_done;
		o_sheet_done |-> o_busy ##1 !o_sheet_done;
	endproperty
	a_done: assert property (p_done) else $error("done pulse");
	property p_door;
		o_busy && i_right_door_switch |-> ##[1:2] o_jam.door_open;
	endproperty
	a_door: assert property (p_door) else $error("door jam missed");
	property p_sticky;
		o_jam.pick_delay && !i_jam_clear |=> o_jam.pick_delay;
	endproperty
	a_sticky: assert property (p_sticky) else $error("jam lost");
endmodule
bind pfc_feeder pfc_feeder_sva pfc_feeder_sva_inst (.*);

// ===== verif/pfc_engine_model.sv
// engine controller model: issues sheet requests
// assumes bench pulses i_go for one cycle
`timescale 1ns/1ps
module pfc_engine_model (
	// from bench and feeder
	input  wire logic       i_core_clk,
	input  wire logic       i_go,
	input  wire logic [1:0] i_tray,
	input  wire logic       i_jam_any,
	input  wire logic       i_busy,
	// to feeder
	output logic            o_pick_req,
	output logic [1:0]      o_pick_tray
);
	initial begin
		o_pick_req = 1'b0;
		o_pick_tray = 2'h0;
	end
	// request held until busy seen, dropped on any jam
	always @(negedge i_core_clk) begin
		if (i_jam_any || i_busy) begin
			o_pick_req <= 1'b0;
		end else if (i_go) begin
			o_pick_req <= 1'b1;
			o_pick_tray <= i_tray;
		end
	end
endmodule

// ===== verif/pfc_feeder_tb.sv
// self-checking bench for the feeder top
// assumes short timeouts, engine model as requester
`timescale 1ns/1ps
module pfc_feeder_tb;
	logic                     i_core_clk, i_sys_rst, i_pick_req, i_printing;
	logic                     i_jam_clear, i_right_door_switch, go;
	logic [1:0]               i_pick_tray, go_tray;
	logic [2:0]               i_upper_size_switches, i_middle_size_switches;
	logic [2:0]               i_lower_size_switches, i_surface_a, i_surface_b;
	logic                     i_upper_feed_sensor, i_middle_feed_sensor;
	logic                     i_lower_feed_sensor, o_sheet_done, o_busy;
	logic                     o_upper_lifter_motor, o_middle_lifter_motor;
	logic                     o_lower_lifter_motor, o_pickup_motor;
	logic [2:0]               o_pickup_solenoid, o_lifter_fail;
	pfc_pkg::pfc_size_t [2:0] o_size;
	pfc_pkg::pfc_jam_t        o_jam;
	int                       n_errors, checks_done;
	pfc_pkg::pfc_size_t       sz_tab [8] = '{pfc_pkg::SZ_NONE, pfc_pkg::SZ_A5,
		pfc_pkg::SZ_LETTER, pfc_pkg::SZ_B5, pfc_pkg::SZ_A4, pfc_pkg::SZ_EXEC,
		pfc_pkg::SZ_LEGAL, pfc_pkg::SZ_UNIVERSAL};
	pfc_feeder #(.TRAYS(3), .LIFT_TIMEOUT(40), .LEAD_TIMEOUT(10),
		.TRAIL_TIMEOUT(20), .RESID_TIME(10), .DELIVER_TIME(15))
		pfc_feeder_inst (.*);
	pfc_engine_model pfc_engine_model_inst (.i_core_clk(i_core_clk),
		.i_go(go), .i_tray(go_tray), .i_jam_any(|o_jam), .i_busy(o_busy),
		.o_pick_req(i_pick_req), .o_pick_tray(i_pick_tray));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	function automatic bit hit(input int s);
		return s == 0 ? |o_pickup_solenoid : o_sheet_done === 1'b1;
	endfunction
	task automatic wait_hi(input int s);
		repeat (20) if (!hit(s)) @(negedge i_core_clk);
	endtask
	task automatic req(input logic [1:0] t);
		go <= 1'b1;
		go_tray <= t;
		tick(1);
		go <= 1'b0;
		wait_hi(0);
	endtask
	task automatic clear_jam();
		i_jam_clear <= 1'b1;
		tick(1);
		i_jam_clear <= 1'b0;
		tick(2);
	endtask
	task automatic t_lift_fail();
		tick(5);
		check(o_upper_lifter_motor, 8'h01);
		i_surface_a <= 3'h7;
		i_surface_b <= 3'h3;
		tick(50);
		check({o_lower_lifter_motor, o_middle_lifter_motor}, 8'h00);
		check(o_lifter_fail, 8'h04);
	endtask
	task automatic t_size();
		for (int s = 0; s < 8; s++) begin
			i_upper_size_switches <= 3'(s);
			tick(3);
			check(o_size[0], sz_tab[s]);
		end
	endtask
	task automatic t_relift();
		i_surface_a[1] <= 1'b0;
		tick(4);
		check(o_middle_lifter_motor, 8'h01);
		i_surface_a[1] <= 1'b1;
		tick(4);
		check(o_middle_lifter_motor, 8'h00);
	endtask
	task automatic t_pick_ok();
		req(2'h1);
		check(o_pickup_solenoid, 8'h02);
		tick(3);
		i_middle_feed_sensor <= 1'b1;
		tick(5);
		i_middle_feed_sensor <= 1'b0;
		wait_hi(1);
		check(o_sheet_done, 8'h01);
		tick(2);
		check(o_busy, 8'h00);
	endtask
	task automatic t_delay_jam();
		int n;
		n = 1;
		req(2'h0);
		repeat (50) begin
			@(negedge i_core_clk);
			n += int'(|o_pickup_solenoid);
		end
		check(8'(n), 8'h03);
		check(o_jam, 8'h30);
		clear_jam();
	endtask
	task automatic t_stat_resid();
		req(2'h1);
		i_middle_feed_sensor <= 1'b1;
		tick(30);
		check(o_jam, 8'h08);
		clear_jam();
		check(o_pickup_motor, 8'h01);
		tick(14);
		check(o_jam, 8'h02);
		i_middle_feed_sensor <= 1'b0;
		clear_jam();
		tick(20);
		check({o_busy, o_jam}, 8'h00);
	endtask
	task automatic t_door();
		req(2'h1);
		i_right_door_switch <= 1'b1;
		tick(3);
		check(o_jam, 8'h01);
		i_right_door_switch <= 1'b0;
		clear_jam();
		check(o_jam, 8'h00);
	endtask
	task automatic t_remove();
		i_lower_size_switches <= 3'h0;
		tick(3);
		check(o_lifter_fail, 8'h00);
		check(o_size[2], pfc_pkg::SZ_NONE);
		i_lower_size_switches <= 3'h5;
		tick(3);
		check(o_lower_lifter_motor, 8'h01);
		check(o_size[2], pfc_pkg::SZ_EXEC);
	endtask
	task automatic t_stat2_deliv();
		req(2'h0);
		check(o_pickup_solenoid, 8'h01);
		i_upper_feed_sensor <= 1'b1;
		tick(30);
		check(o_jam, 8'h04);
		i_upper_feed_sensor <= 1'b0;
		i_lower_feed_sensor <= 1'b1;
		clear_jam();
		check(o_pickup_motor, 8'h01);
		i_lower_feed_sensor <= 1'b0;
		tick(10);
		check(o_pickup_motor, 8'h01);
		tick(10);
		check({o_busy, o_pickup_motor, o_jam}, 8'h00);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		#300000;
		n_errors++;
		print_verdict();
	end
	initial begin
		{i_sys_rst, i_printing, go, go_tray, i_jam_clear} = 6'h30;
		{i_right_door_switch, i_surface_a, i_surface_b} = 7'h00;
		{i_upper_feed_sensor, i_middle_feed_sensor} = 2'h0;
		i_lower_feed_sensor = 1'b0;
		i_upper_size_switches = 3'h7;
		i_middle_size_switches = 3'h7;
		i_lower_size_switches = 3'h7;
		tick(3);
		i_sys_rst <= 1'b0;
		t_lift_fail();
		t_remove();
		t_size();
		t_relift();
		t_pick_ok();
		t_delay_jam();
		t_stat_resid();
		t_door();
		t_stat2_deliv();
		print_verdict();
	end
endmodule
